/* File: src/tcf_consts.vh */
// constants for the timer capture and interrupt flag block
`ifndef TCF_CONSTS_VH
`define TCF_CONSTS_VH
`define TCF_ADDR_MASK 3'h0
`define TCF_ADDR_FLAGS 3'h1
`define TCF_ADDR_CAP_LO 3'h2
`define TCF_ADDR_CAP_HI 3'h3
`define TCF_ADDR_CTRL 3'h4
`define TCF_BIT_CAP 5
`define TCF_BIT_CMPA 4
`define TCF_BIT_CMPB 3
`define TCF_BIT_OVF 2
`define TCF_CTRL_EDGE 0
`define TCF_CTRL_FILT 1
`define TCF_CTRL_ACMP 2
`define TCF_RESET_BYTE 8'h00
`define TCF_FILTER_LEN 4
`define TCF_MODE_NORMAL 4'h0
`define TCF_MODE_CTC_A 4'h4
`define TCF_MODE_PFC_ICR 4'h8
`define TCF_MODE_PC_ICR 4'hA
`define TCF_MODE_CTC_ICR 4'hC
`define TCF_MODE_FAST_ICR 4'hE
`endif

/* File: src/tcf_input_filter.v */
// capture input noise filter
`include "tcf_consts.vh"
module tcf_input_filter
(
    input wire clock_i,
    input wire resetn_i,
    input wire enable_i,
    input wire sample_i,
    output wire level_o
);
    reg [`TCF_FILTER_LEN-1:0] history;
    reg filtered;
    wire all_high;
    wire all_low;
    assign all_high = &history;
    assign all_low = ~|history;
    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            history <= {`TCF_FILTER_LEN{1'b1}};
            filtered <= 1'b1;
        end
        else
        begin
            history <= {history[`TCF_FILTER_LEN-2:0], sample_i};
            if (all_high)
                filtered <= 1'b1;
            else if (all_low)
                filtered <= 1'b0;
        end
    end
    // bypass keeps the raw synchronised level
    assign level_o = enable_i ? filtered : sample_i;
endmodule

/* File: src/tcf_capture_flags.v */
// timer capture register, interrupt mask and flag logic
//
// The implementer's own choices: strobed register access and the register offsets.
`include "tcf_consts.vh"
module tcf_capture_flags
(
    input wire clock_i,
    input wire resetn_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire write_i,
    input wire read_i,
    output reg [7:0] rdata_o,
    input wire [15:0] counter_value_i,
    input wire [15:0] compare_register_a_i,
    input wire [15:0] compare_register_b_i,
    input wire [3:0] waveform_mode_select_i,
    input wire counter_tick_i,
    input wire counter_overflow_i,
    input wire counter_at_top_i,
    input wire counter_at_bottom_i,
    input wire force_compare_a_strobe_i,
    input wire force_compare_b_strobe_i,
    input wire capture_input_pin_i,
    input wire comparator_out_i,
    input wire global_irq_enable_i,
    input wire capture_vector_ack_i,
    input wire compare_a_vector_ack_i,
    input wire compare_b_vector_ack_i,
    input wire overflow_vector_ack_i,
    output reg [7:0] temp_high_o,
    output wire [15:0] capture_register_o,
    output wire top_is_capture_o,
    output wire capture_irq_o,
    output wire compare_a_irq_o,
    output wire compare_b_irq_o,
    output wire overflow_irq_o
);
    reg [7:0] timer_irq_enable_mask;
    reg [7:0] timer_irq_flags;
    reg [2:0] control;
    reg [15:0] capture_register;
    reg pin_meta;
    reg pin_sync;
    reg cmp_meta;
    reg cmp_sync;
    reg prev_level;
    reg match_a_seen;
    reg match_b_seen;
    reg [7:0] next_flags;
    wire filtered_pin;
    wire capture_src;
    wire edge_hit;
    wire capture_event;
    wire icr_top;
    wire ovf_set;
    wire phase_mode;
    wire flag_write;

    // pin and comparator cross into this clock through two stages
    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= capture_input_pin_i;
            pin_sync <= pin_meta;
            cmp_meta <= comparator_out_i;
            cmp_sync <= cmp_meta;
        end
    end

    tcf_input_filter u_filter
    (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .enable_i(control[`TCF_CTRL_FILT]),
        .sample_i(pin_sync),
        .level_o(filtered_pin)
    );

    assign icr_top = (waveform_mode_select_i == `TCF_MODE_PFC_ICR) ||
                     (waveform_mode_select_i == `TCF_MODE_PC_ICR) ||
                     (waveform_mode_select_i == `TCF_MODE_CTC_ICR) ||
                     (waveform_mode_select_i == `TCF_MODE_FAST_ICR);
    assign top_is_capture_o = icr_top;
    assign phase_mode = (waveform_mode_select_i[3:2] == 2'b10) ||
                        (waveform_mode_select_i[3:2] == 2'b00 &&
                         waveform_mode_select_i != `TCF_MODE_NORMAL);

    assign capture_src = control[`TCF_CTRL_ACMP] ? cmp_sync : filtered_pin;
    assign edge_hit = control[`TCF_CTRL_EDGE] ?
                      (capture_src & ~prev_level) :
                      (~capture_src & prev_level);
    // pin is disconnected while the capture register is TOP
    assign capture_event = edge_hit & ~icr_top;

    // overflow point by mode: MAX for normal/ctc, TOP for fast,
    // BOTTOM for phase modes
    assign ovf_set = counter_tick_i & (phase_mode ? counter_at_bottom_i :
        ((waveform_mode_select_i == `TCF_MODE_NORMAL ||
          waveform_mode_select_i == `TCF_MODE_CTC_A ||
          waveform_mode_select_i == `TCF_MODE_CTC_ICR) ?
          counter_overflow_i : counter_at_top_i));

    assign flag_write = write_i && addr_i == `TCF_ADDR_FLAGS;

    always @*
    begin
        next_flags = timer_irq_flags;
        if (flag_write)
            next_flags = timer_irq_flags & ~wdata_i;
        if (capture_vector_ack_i)
            next_flags[`TCF_BIT_CAP] = 1'b0;
        if (compare_a_vector_ack_i)
            next_flags[`TCF_BIT_CMPA] = 1'b0;
        if (compare_b_vector_ack_i)
            next_flags[`TCF_BIT_CMPB] = 1'b0;
        if (overflow_vector_ack_i)
            next_flags[`TCF_BIT_OVF] = 1'b0;
        // sets come last so a same-cycle event wins over a clear
        if (capture_event || (icr_top && counter_tick_i &&
            counter_at_top_i))
            next_flags[`TCF_BIT_CAP] = 1'b1;
        if (match_a_seen)
            next_flags[`TCF_BIT_CMPA] = 1'b1;
        if (match_b_seen)
            next_flags[`TCF_BIT_CMPB] = 1'b1;
        if (ovf_set)
            next_flags[`TCF_BIT_OVF] = 1'b1;
        next_flags[7:6] = 2'b00;
        next_flags[1:0] = 2'b00;
    end

    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            timer_irq_enable_mask <= `TCF_RESET_BYTE;
            timer_irq_flags <= `TCF_RESET_BYTE;
            control <= 3'h0;
            capture_register <= 16'h0000;
            temp_high_o <= 8'h00;
            prev_level <= 1'b1;
            match_a_seen <= 1'b0;
            match_b_seen <= 1'b0;
            rdata_o <= 8'h00;
        end
        else
        begin
            prev_level <= capture_src;
            timer_irq_flags <= next_flags;
            // match registered so flag rises one clock later, whatever the next tick;
            // a forced strobe blocks the match in the cycle it is driven
            match_a_seen <= counter_tick_i &&
                counter_value_i == compare_register_a_i &&
                !force_compare_a_strobe_i;
            match_b_seen <= counter_tick_i &&
                counter_value_i == compare_register_b_i &&
                !force_compare_b_strobe_i;
            if (capture_event)
                capture_register <= counter_value_i;
            if (write_i)
            begin
                case (addr_i)
                    `TCF_ADDR_MASK:
                        timer_irq_enable_mask <= wdata_i & 8'h3C;
                    `TCF_ADDR_CTRL:
                        control <= wdata_i[2:0];
                    default:
                        control <= control;
                endcase
            end
            rdata_o <= 8'h00;
            if (read_i)
            begin
                case (addr_i)
                    `TCF_ADDR_MASK:
                        rdata_o <= timer_irq_enable_mask;
                    `TCF_ADDR_FLAGS:
                        rdata_o <= timer_irq_flags;
                    `TCF_ADDR_CAP_LO:
                    begin
                        rdata_o <= capture_register[7:0];
                        temp_high_o <= capture_register[15:8];
                    end
                    `TCF_ADDR_CAP_HI:
                        rdata_o <= temp_high_o;
                    `TCF_ADDR_CTRL:
                        rdata_o <= {5'h00, control};
                    default:
                        rdata_o <= 8'h00;
                endcase
            end
        end
    end

    assign capture_register_o = capture_register;
    assign capture_irq_o = timer_irq_enable_mask[`TCF_BIT_CAP] &
        global_irq_enable_i & timer_irq_flags[`TCF_BIT_CAP];
    assign compare_a_irq_o = timer_irq_enable_mask[`TCF_BIT_CMPA] &
        global_irq_enable_i & timer_irq_flags[`TCF_BIT_CMPA];
    assign compare_b_irq_o = timer_irq_enable_mask[`TCF_BIT_CMPB] &
        global_irq_enable_i & timer_irq_flags[`TCF_BIT_CMPB];
    assign overflow_irq_o = timer_irq_enable_mask[`TCF_BIT_OVF] &
        global_irq_enable_i & timer_irq_flags[`TCF_BIT_OVF];
endmodule

/* File: tb/tcf_capture_flags_checker.sv */
// assertions on the capture and flag block ports
module tcf_capture_flags_checker
(
    input logic clock_i,
    input logic resetn_i,
    input logic [2:0] addr_i,
    input logic read_i,
    input logic [15:0] counter_value_i,
    input logic [15:0] compare_register_a_i,
    input logic [3:0] waveform_mode_select_i,
    input logic counter_tick_i,
    input logic force_compare_a_strobe_i,
    input logic global_irq_enable_i,
    input logic compare_a_vector_ack_i,
    input logic overflow_vector_ack_i,
    input logic [7:0] temp_high_o,
    input logic [15:0] capture_register_o,
    input logic top_is_capture_o,
    input logic capture_irq_o,
    input logic compare_a_irq_o,
    input logic compare_b_irq_o,
    input logic overflow_irq_o
);
default clocking @(posedge clock_i); endclocking
default disable iff (!resetn_i);
property p_temp; read_i && addr_i == 3'h2 |=>
    temp_high_o == $past(capture_register_o[15:8]); endproperty
a_temp: assert property (p_temp)
    else $error("temp high byte wrong");
property p_top; top_is_capture_o == (waveform_mode_select_i inside
    {4'h8, 4'hA, 4'hC, 4'hE}); endproperty
a_top: assert property (p_top)
    else $error("capture top decode wrong");
property p_cap; !global_irq_enable_i |-> !capture_irq_o; endproperty
a_cap: assert property (p_cap)
    else $error("capture irq without global");
property p_cma; !global_irq_enable_i |-> !compare_a_irq_o; endproperty
a_cma: assert property (p_cma)
    else $error("compare a irq without global");
property p_cmb; !global_irq_enable_i |-> !compare_b_irq_o; endproperty
a_cmb: assert property (p_cmb)
    else $error("compare b irq without global");
property p_ovf; !global_irq_enable_i |-> !overflow_irq_o; endproperty
a_ovf: assert property (p_ovf)
    else $error("overflow irq without global");
property p_acka; compare_a_vector_ack_i && !$past(counter_tick_i &&
    counter_value_i == compare_register_a_i && !force_compare_a_strobe_i)
    |=> !compare_a_irq_o; endproperty
a_acka: assert property (p_acka)
    else $error("compare a flag not cleared");
property p_acko; overflow_vector_ack_i && !counter_tick_i
    |=> !overflow_irq_o; endproperty
a_acko: assert property (p_acko)
    else $error("overflow flag not cleared");
endmodule
bind tcf_capture_flags tcf_capture_flags_checker chk (.clock_i, .resetn_i,
    .addr_i, .read_i, .counter_value_i, .compare_register_a_i,
    .waveform_mode_select_i, .counter_tick_i, .force_compare_a_strobe_i,
    .global_irq_enable_i, .compare_a_vector_ack_i, .overflow_vector_ack_i,
    .temp_high_o, .capture_register_o, .top_is_capture_o, .capture_irq_o,
    .compare_a_irq_o, .compare_b_irq_o, .overflow_irq_o);

/* File: tb/test_timer1_capture_and_irq_flags.sv */
// self-checking bench for the capture and flag block
module test_timer1_capture_and_irq_flags;
timeunit 1ns;
timeprecision 100ps;
logic clock_i, resetn_i = 1'h0, write_i = 1'h0, read_i = 1'h0;
logic [2:0] addr_i = 3'h0;
logic [7:0] wdata_i = 8'h00, rdata_o, temp_high_o;
logic [15:0] counter_value_i = 16'h0000, capture_register_o, cv;
logic [15:0] compare_register_a_i = 16'h0001, compare_register_b_i = 16'h0001;
logic [3:0] waveform_mode_select_i = 4'h0, tq = 4'h0, ackv = 4'h0;
logic counter_tick_i = 1'h0, capture_input_pin_i = 1'h1;
logic comparator_out_i = 1'h0, counter_at_bottom_i = 1'h0;
logic global_irq_enable_i = 1'h0, top_is_capture_o;
logic counter_overflow_i, counter_at_top_i, force_compare_a_strobe_i;
logic force_compare_b_strobe_i, capture_vector_ack_i, compare_a_vector_ack_i;
logic compare_b_vector_ack_i, overflow_vector_ack_i;
logic capture_irq_o, compare_a_irq_o, compare_b_irq_o, overflow_irq_o;
int err_count, comparisons, mf, mm, i, k;
assign {counter_overflow_i, counter_at_top_i, force_compare_a_strobe_i,
    force_compare_b_strobe_i} = tq;
assign {capture_vector_ack_i, compare_a_vector_ack_i, compare_b_vector_ack_i,
    overflow_vector_ack_i} = ackv;
tcf_capture_flags uut (.*);
task cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
        err_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    write_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    write_i <= 1'h0;
endtask
task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_i);
    read_i <= 1'h1;
    addr_i <= a;
    @(posedge clock_i);
    read_i <= 1'h0;
    #1 cmp(rdata_o, e);
endtask
// qualifiers held one tick, then settle time for the flag
task tk(input logic [3:0] v);
    @(posedge clock_i);
    counter_tick_i <= 1'h1;
    tq <= v;
    @(posedge clock_i);
    counter_tick_i <= 1'h0;
    tq <= 4'h0;
    repeat (3) @(posedge clock_i);
endtask
task ic;
    @(posedge clock_i);
    #1 cmp({4'h0, capture_irq_o, compare_a_irq_o, compare_b_irq_o,
        overflow_irq_o}, global_irq_enable_i ? 8'((mf & mm) >> 2) : 8'h00);
endtask
task close_out;
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
initial
begin
    clock_i = 1'h0;
    forever #12.5 clock_i = ~clock_i;
end
initial
begin
    #500us;
    err_count++;
    close_out;
end
initial
begin
    void'($urandom(32'h0571));
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'h1;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h0, 8'hFF);
    mm = 8'h3C;
    rd(3'h0, 8'h3C);
    rd(3'h5, 8'h00);
    @(posedge clock_i) global_irq_enable_i <= 1'h1;
    for (i = 0; i < 3; i++)
    begin
        cv = 16'($urandom);
        counter_value_i <= cv;
        compare_register_a_i <= (i == 0) ? cv : ~cv;
        compare_register_b_i <= (i == 1) ? cv : ~cv;
        tk(4'h3);
        rd(3'h1, 8'(mf));
        tk({i == 2, 3'h0});
        mf |= 8'h10 >> i;
        rd(3'h1, 8'(mf));
        ic;
    end
    wr(3'h1, 8'h00);
    rd(3'h1, 8'(mf));
    @(posedge clock_i) global_irq_enable_i <= 1'h0;
    ic;
    @(posedge clock_i) global_irq_enable_i <= 1'h1;
    for (i = 0; i < 3; i++)
    begin
        @(posedge clock_i) ackv <= 4'h4 >> i;
        @(posedge clock_i) ackv <= 4'h0;
        mf &= ~(8'h10 >> i);
        ic;
    end
    wr(3'h0, 8'h00);
    mm = 0;
    compare_register_a_i <= cv;
    tk(4'h0);
    mf = 8'h10;
    ic;
    wr(3'h0, 8'h3C);
    mm = 8'h3C;
    ic;
    wr(3'h1, 8'h10);
    mf = 0;
    rd(3'h1, 8'h00);
    // first setup edge is a valid one and captures zero; the edge at FFFF is the opposite one and is ignored
    for (k = 0; k < 4; k++)
    begin
        wr(3'h4, 8'(k));
        counter_value_i <= 16'h0000;
        capture_input_pin_i <= k[0];
        repeat (12) @(posedge clock_i);
        counter_value_i <= 16'hFFFF;
        capture_input_pin_i <= ~k[0];
        repeat (12) @(posedge clock_i);
        rd(3'h2, 8'h00);
        cv = 16'($urandom);
        @(posedge clock_i) counter_value_i <= cv;
        capture_input_pin_i <= k[0];
        repeat (12) @(posedge clock_i);
        rd(3'h2, cv[7:0]);
        rd(3'h3, cv[15:8]);
        mf = 8'h20;
        ic;
        wr(3'h1, 8'h20);
        mf = 0;
        rd(3'h1, 8'h00);
    end
    // comparator as source, rising edge, filter off
    wr(3'h4, 8'h05);
    cv = 16'($urandom);
    @(posedge clock_i) counter_value_i <= cv;
    comparator_out_i <= 1'h1;
    repeat (12) @(posedge clock_i);
    rd(3'h2, cv[7:0]);
    rd(3'h1, 8'h20);
    wr(3'h1, 8'h20);
    @(posedge clock_i) waveform_mode_select_i <= 4'hC;
    tk(4'h4);
    rd(3'h1, 8'h20);
    close_out;
end
endmodule
